// file: sim/eeprom_chk.sv
// assertion checker on the pins of the serial eeprom command port
`timescale 1ns/1ps
module eeprom_chk #(
	parameter logic [eeprom_pkg::TIMER_W-1:0] PROG_CYCLES = eeprom_pkg::PROG_CYCLES
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic chip_select_line,
	input wire logic serial_clock_line,
	input wire logic serial_in_line,
	input wire logic bulk_program_allow,
	input wire logic serial_out_line,
	input wire logic serial_out_oe
);
	// ************************************************************
	// helper state
	// ************************************************************
	logic [7:0]      sel_age;  // cycles since select rose, saturating
	logic            oe_q;     // enable one cycle back
	logic            rd_mode;  // enable belongs to a read
	logic            st_mode;  // enable belongs to a status indication
	logic [7:0]      rd_len;   // cycles a read has driven the line
	logic [19:0]     busy_cnt; // cycles the status has shown busy
	wire logic       oe_rise = serial_out_oe & ~oe_q;
	wire logic [7:0] next_age = (sel_age == 8'hFF) ? sel_age : sel_age + 8'h01;
	// a status enable rises a few cycles after select, a read one deep in a frame
	always_ff @(posedge sys_clk) begin
		sel_age <= (srst || !chip_select_line) ? 8'h00 : next_age;
		oe_q <= srst ? 1'b0 : serial_out_oe;
		rd_len <= oe_rise ? 8'h01 : rd_len + {7'h00, serial_out_oe};
		busy_cnt <= (st_mode && serial_out_oe && !serial_out_line) ? busy_cnt + 20'h00001 : 20'h00000;
	end
	// classify each enable period once, at its start
	always_ff @(posedge sys_clk) begin
		if (srst || !serial_out_oe) begin
			rd_mode <= 1'b0;
			st_mode <= 1'b0;
		end else if (oe_rise) begin
			rd_mode <= sel_age > 8'h10;
			st_mode <= sel_age <= 8'h08;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	property p_reset_idle;
		disable iff (1'b0) srst |=> !serial_out_oe && serial_out_line;
	endproperty
	property p_float;
		!chip_select_line [*5] |-> !serial_out_oe;
	endproperty
	property p_no_stray;
		oe_rise |-> (sel_age <= 8'h08 || sel_age >= 8'h3C);
	endproperty
	property p_dummy_zero;
		oe_rise && sel_age > 8'h10 |-> !serial_out_line;
	endproperty
	property p_rd_edge;
		rd_mode && oe_q && serial_out_oe && $changed(serial_out_line) |-> serial_clock_line;
	endproperty
	// length holds for the 160 ns link period that the bench uses
	property p_rd_len;
		rd_mode && oe_q && !serial_out_oe && chip_select_line |-> rd_len >= 8'h87 && rd_len <= 8'h89;
	endproperty
	property p_status_mono;
		st_mode && oe_q && serial_out_oe |-> !$fell(serial_out_line);
	endproperty
	property p_busy_bound;
		busy_cnt <= PROG_CYCLES;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("output not idle after reset");
	a_float: assert property (p_float) else $error("output driven without select");
	a_no_stray: assert property (p_no_stray) else $error("output enabled at odd time");
	a_dummy_zero: assert property (p_dummy_zero) else $error("read lead bit not zero");
	a_rd_edge: assert property (p_rd_edge) else $error("read data moved while clock low");
	a_rd_len: assert property (p_rd_len) else $error("read drive length wrong");
	a_status_mono: assert property (p_status_mono) else $error("status fell back to busy");
	a_busy_bound: assert property (p_busy_bound) else $error("program cycle too long");
	c_read: cover property (rd_mode && serial_out_oe);
	c_busy: cover property (busy_cnt == 20'h00010);
	c_ready: cover property (st_mode && serial_out_line);
endmodule // eeprom_chk
bind serial_eeprom_command_port eeprom_chk #(.PROG_CYCLES(PROG_CYCLES)) i_eeprom_chk (
	.sys_clk(sys_clk), .srst(srst), .chip_select_line(chip_select_line),
	.serial_clock_line(serial_clock_line), .serial_in_line(serial_in_line),
	.bulk_program_allow(bulk_program_allow), .serial_out_line(serial_out_line),
	.serial_out_oe(serial_out_oe));

// file: sim/host_model.sv
// host model that drives the serial instruction link of the eeprom port
`timescale 1ns/1ps
module host_model (
	input  wire logic sys_clk,           // core clock, used for pacing only
	output logic      chip_select_line,  // select, raised on falling sys_clk
	output logic      serial_clock_line, // link clock, stands low between frames
	output logic      serial_in_line     // serial data towards the device
);
	// idle pins at time zero
	initial begin
		chip_select_line = 1'b0;
		serial_clock_line = 1'b0;
		serial_in_line = 1'b0;
	end
	// raise select; the 13 ns skew keeps link edges off the sys_clk grid
	task automatic open_frame();
		@(negedge sys_clk);
		chip_select_line = 1'b1;
		repeat (5) @(negedge sys_clk);
		#13;
	endtask
	// one 160 ns link period, data set up half a phase before the rising edge
	task automatic clk_bit(input logic b);
		serial_in_line = b;
		#40 serial_clock_line = 1'b1;
		#80 serial_clock_line = 1'b0;
		#40;
	endtask
	// drop select and keep it low for over 1 us; released data line toggles
	task automatic close_frame();
		@(negedge sys_clk);
		chip_select_line = 1'b0;
		serial_in_line = ~serial_in_line;
		repeat (55) @(negedge sys_clk);
	endtask
	// start bit, op code and address, most significant first
	task automatic send_hdr(input logic [1:0] op, input logic [5:0] a);
		logic [8:0] h;
		h = {1'b1, op, a};
		for (int i = 8; i >= 0; i--) clk_bit(h[i]);
	endtask
	// data bits; autoerase drops select before the falling edge after d0
	task automatic send_data(input logic [15:0] d, input logic auto);
		for (int i = 15; i >= 1; i--) clk_bit(d[i]);
		serial_in_line = d[0];
		#40 serial_clock_line = 1'b1;
		if (auto) begin
			#40 chip_select_line = 1'b0;
			#40 serial_clock_line = 1'b0;
		end else begin
			#80 serial_clock_line = 1'b0;
		end
		#40;
	endtask
endmodule // host_model

// file: sim/tb.sv
// self-checking testbench of the serial eeprom command port
`timescale 1ns/1ps
module tb;
	logic        sys_clk;            // core clock
	logic        srst;               // synchronous reset
	logic        bulk_program_allow; // bulk allow pin, high when left open
	wire logic   cs, sk, di, so, oe; // link pins
	int          err_count;
	int          samples_checked;
	logic [15:0] mem [64];           // expected array contents
	// short program cycle keeps the run brief
	serial_eeprom_command_port #(.PROG_CYCLES(20'h000C8)) i_serial_eeprom_command_port (
		.sys_clk(sys_clk), .srst(srst), .chip_select_line(cs), .serial_clock_line(sk),
		.serial_in_line(di), .bulk_program_allow(bulk_program_allow),
		.serial_out_line(so), .serial_out_oe(oe));
	host_model i_host_model (.sys_clk(sys_clk), .chip_select_line(cs),
		.serial_clock_line(sk), .serial_in_line(di));
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", what, exp, got);
			err_count++;
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// read a word after some leading zeros; data line toggles once released
	task automatic rd(input logic [5:0] a, input int lead);
		logic [15:0] w;
		i_host_model.open_frame();
		repeat (lead) i_host_model.clk_bit(1'b0);
		i_host_model.send_hdr(eeprom_pkg::OP_READ, a);
		chk("dummy enable", 16'h0001, {15'h0000, oe});
		chk("dummy bit", 16'h0000, {15'h0000, so});
		for (int i = 15; i >= 0; i--) begin
			i_host_model.clk_bit(~di);
			w[i] = so;
		end
		chk("read word", mem[a], w);
		i_host_model.clk_bit(~di);
		chk("read release", 16'h0000, {15'h0000, oe});
		i_host_model.close_frame();
	endtask
	// one instruction, then a status frame: busy then ready, or nothing driven
	task automatic prog(input logic [1:0] op, input logic [5:0] a, input logic [15:0] d,
		input logic nd, input logic auto, input logic busy);
		int n;
		i_host_model.open_frame();
		i_host_model.send_hdr(op, a);
		if (nd) i_host_model.send_data(d, auto);
		i_host_model.close_frame();
		i_host_model.open_frame();
		repeat (3) @(negedge sys_clk);
		chk("status enable", {15'h0000, busy}, {15'h0000, oe});
		if (busy) begin
			chk("busy level", 16'h0000, {15'h0000, so});
			n = 0;
			while (so !== 1'b1 && n < 400) begin
				@(negedge sys_clk);
				n++;
			end
			chk("ready level", 16'h0001, {15'h0000, so});
		end
		i_host_model.close_frame();
	endtask
	task automatic t_power_up();
		chk("idle enable", 16'h0000, {15'h0000, oe});
		rd(6'h00, 0);
		rd(6'h3F, 3);
		i_host_model.open_frame();
		i_host_model.clk_bit(1'b1);
		i_host_model.clk_bit(1'b1);
		i_host_model.close_frame();
		rd(6'h01, 0);
	endtask
	task automatic t_locked();
		prog(eeprom_pkg::OP_WRITE, 6'h05, 16'h1234, 1'b1, 1'b1, 1'b0);
		prog(eeprom_pkg::OP_EXT, {eeprom_pkg::SUB_WRALL, 4'h0}, 16'h0000, 1'b1, 1'b0, 1'b0);
		rd(6'h05, 0);
	endtask
	task automatic t_single();
		prog(eeprom_pkg::OP_EXT, {eeprom_pkg::SUB_EN, 4'h0}, 16'h0000, 1'b0, 1'b0, 1'b0);
		prog(eeprom_pkg::OP_WRITE, 6'h05, 16'h1234, 1'b1, 1'b0, 1'b1);
		mem[5] = 16'h1234;
		rd(6'h05, 0);
		prog(eeprom_pkg::OP_ERASE, 6'h05, 16'h0000, 1'b0, 1'b0, 1'b1);
		mem[5] = 16'hFFFF;
		rd(6'h05, 0);
		prog(eeprom_pkg::OP_WRITE, 6'h05, 16'hFF00, 1'b1, 1'b1, 1'b1);
		mem[5] = 16'hFF00;
		prog(eeprom_pkg::OP_WRITE, 6'h05, 16'h0FF0, 1'b1, 1'b0, 1'b1);
		mem[5] = 16'h0F00;
		rd(6'h05, 0);
	endtask
	task automatic t_bulk();
		@(negedge sys_clk);
		bulk_program_allow = 1'b0;
		prog(eeprom_pkg::OP_EXT, {eeprom_pkg::SUB_ERALL, 4'h0}, 16'h0000, 1'b0, 1'b0, 1'b0);
		rd(6'h05, 0);
		prog(eeprom_pkg::OP_EXT, {eeprom_pkg::SUB_WRALL, 4'h0}, 16'h0000, 1'b1, 1'b0, 1'b0);
		prog(eeprom_pkg::OP_WRITE, 6'h09, 16'h00FF, 1'b1, 1'b1, 1'b1);
		mem[9] = 16'h00FF;
		rd(6'h00, 0);
		@(negedge sys_clk);
		bulk_program_allow = 1'b1;
		prog(eeprom_pkg::OP_EXT, {eeprom_pkg::SUB_WRALL, 4'h0}, 16'hA5A5, 1'b1, 1'b0, 1'b1);
		foreach (mem[i]) mem[i] = mem[i] & 16'hA5A5;
		rd(6'h09, 0);
		rd(6'h3F, 0);
		prog(eeprom_pkg::OP_EXT, {eeprom_pkg::SUB_ERALL, 4'h0}, 16'h0000, 1'b0, 1'b0, 1'b1);
		foreach (mem[i]) mem[i] = 16'hFFFF;
		rd(6'h05, 0);
	endtask
	task automatic t_disable();
		prog(eeprom_pkg::OP_EXT, {eeprom_pkg::SUB_DIS, 4'h0}, 16'h0000, 1'b0, 1'b0, 1'b0);
		prog(eeprom_pkg::OP_WRITE, 6'h05, 16'h0000, 1'b1, 1'b0, 1'b0);
		rd(6'h05, 0);
	endtask
	// main sequence: reset held 16 cycles, then the scenarios in order
	initial begin
		err_count = 0;
		samples_checked = 0;
		srst = 1'b1;
		bulk_program_allow = 1'b1;
		foreach (mem[i]) mem[i] = 16'hFFFF;
		repeat (16) @(negedge sys_clk);
		srst = 1'b0;
		repeat (4) @(negedge sys_clk);
		t_power_up();
		t_locked();
		t_single();
		t_bulk();
		t_disable();
		close_out();
	end
	// watchdog: the scenarios need well under a millisecond
	initial begin
		#1_500_000;
		err_count++;
		close_out();
	end
endmodule // tb

// file: verilog/eeprom_pkg.sv
// constants and types shared by the serial eeprom command port
package eeprom_pkg;

	// ************************************************************
	// clock and self-timed cycle
	// ************************************************************
	localparam int SYS_CLK_NS   = 20;         // sys_clk period
	localparam int PROG_TIME_NS = 10_000_000; // longest program cycle
	localparam int TIMER_W      = 20;         // program timer width
	// longest time, so the division rounds down
	localparam logic [TIMER_W-1:0] PROG_CYCLES = TIMER_W'(PROG_TIME_NS / SYS_CLK_NS);
	localparam logic [TIMER_W-1:0] TIMER_LAST  = 20'h00001;

	// ************************************************************
	// array and instruction layout
	// ************************************************************
	localparam int WORD_W = 16;               // bits per word
	localparam int ADDR_W = 6;                // address bits
	localparam int WORDS  = 64;               // words in the array
	localparam int HDR_W  = 8;                // op code plus address
	localparam int OP_HI  = 7;                // op code field, high bit
	localparam int OP_LO  = 6;                // op code field, low bit
	localparam int SUB_HI = 5;                // sub-code field, high bit
	localparam int SUB_LO = 4;                // sub-code field, low bit
	localparam logic [WORD_W-1:0] WORD_ERASED = 16'hFFFF;

	// ************************************************************
	// op codes and sub-codes of the extended op code
	// ************************************************************
	localparam logic [1:0] OP_EXT    = 2'h0;
	localparam logic [1:0] OP_WRITE  = 2'h1;
	localparam logic [1:0] OP_READ   = 2'h2;
	localparam logic [1:0] OP_ERASE  = 2'h3;
	localparam logic [1:0] SUB_DIS   = 2'h0;  // program_disable_cmd
	localparam logic [1:0] SUB_WRALL = 2'h1;  // write_all_cmd
	localparam logic [1:0] SUB_ERALL = 2'h2;  // erase_all_cmd
	localparam logic [1:0] SUB_EN    = 2'h3;  // program_enable_cmd

	// ************************************************************
	// bit counts on the link and pin reset values
	// ************************************************************
	localparam logic [4:0] CNT_HDR_LAST  = 5'h07; // last header bit
	localparam logic [4:0] CNT_RD_FIRST  = 5'h08; // first data bit out
	localparam logic [4:0] CNT_DATA_LAST = 5'h17; // last data bit in/out
	localparam logic [4:0] CNT_RD_END    = 5'h18; // output released
	localparam logic [1:0] PIN_RESET     = 2'h2;  // {bulk high, select low}
	localparam int PIN_SEL  = 0;              // chip select in pin vector
	localparam int PIN_BULK = 1;              // bulk allow in pin vector

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [4:0] {
		LS_IDLE = 5'h01,
		LS_HDR  = 5'h02,
		LS_DATA = 5'h04,
		LS_READ = 5'h08,
		LS_DONE = 5'h10
	} link_state_t;

	typedef enum logic [1:0] {
		PK_ERASE = 2'h0,
		PK_WRITE = 2'h1,
		PK_AUTO  = 2'h2
	} prog_kind_t;

endpackage

// file: verilog/serial_eeprom_command_port.sv
// serial eeprom command port: link shifter, program sequencer, array
//
// Notes on behaviour
// - read alone drives data, from a loaded word
// - a zero dummy bit leads read data
// - output changes on rising serial clock
// - powers up disabled; enable before programming
// - enable holds until disable instruction
// - reads work whether enabled or not
// - erase cycle starts at chip select fall
// - erase sets word to ones, then ready
// - busy drives low, ready drives high
// - plain write only clears bits
// - autoerase write: select falls before falling edge
// - erase all obeys bulk allow pin
// - write all obeys bulk allow pin
// - a one start bit opens instructions
// - op code and address decode as listed
// - serial clock may stop during cycle
// - output floats outside read and status
// - self-timed cycle ends within 10 ms
// - enable, disable, single ops ignore bulk pin
`timescale 1ns/1ps

module serial_eeprom_command_port #(
	parameter logic [eeprom_pkg::TIMER_W-1:0] PROG_CYCLES = eeprom_pkg::PROG_CYCLES
) (
	input  wire logic sys_clk,            // core clock
	input  wire logic srst,               // reset, active high; synchronous in the core domain, asynchronous in the link domain
	input  wire logic chip_select_line,   // chip select pin
	input  wire logic serial_clock_line,  // serial clock pin, link clock
	input  wire logic serial_in_line,     // serial data in pin
	input  wire logic bulk_program_allow, // bulk programming allow pin
	output wire logic serial_out_line,    // serial data out level
	output wire logic serial_out_oe       // serial data out drive enable
);

	// ************************************************************
	// link domain declarations
	// ************************************************************
	eeprom_pkg::link_state_t         state;     // link sequencer
	logic [4:0]                      cnt;       // bit counter in frame
	logic [eeprom_pkg::HDR_W-1:0]    hdr_sh;    // op code and address
	logic [eeprom_pkg::WORD_W-1:0]   data_sh;   // write data
	logic [eeprom_pkg::WORD_W-1:0]   out_sh;    // read data shifter
	logic                            link_do;   // read output bit
	logic                            rd_oe;     // read drives the pin
	logic                            read_req;  // read word wanted
	logic                            data_done; // last data bit taken
	logic                            done_seen; // falling-edge history
	logic                            cmd_tgl;   // instruction complete
	logic                            plain_tgl; // plain write seen

	// ************************************************************
	// core domain declarations
	// ************************************************************
	logic [1:0]                      pin_q1;    // pin sync, first stage
	logic [1:0]                      pin_q2;    // pin sync, second stage
	logic [1:0]                      pin_q3;    // pin sync, third stage
	logic [1:0]                      pin_state; // debounced pin levels
	logic [2:0]                      lk_s1;     // link sync, first stage
	logic [2:0]                      lk_s2;     // link sync, second stage
	logic [1:0]                      lk_s3;     // toggle history
	logic                            pend;      // instruction waiting
	logic                            pend_plain;// it was a plain write
	logic [eeprom_pkg::HDR_W-1:0]    pend_hdr;  // its header
	logic [eeprom_pkg::WORD_W-1:0]   pend_data; // its data
	logic                            prog_en;   // programming allowed
	logic                            busy;      // self-timed cycle runs
	logic [eeprom_pkg::TIMER_W-1:0]  timer;     // cycles left
	logic                            armed;     // status indication on
	eeprom_pkg::prog_kind_t          prog_kind; // what the cycle does
	logic                            prog_all;  // cycle hits every word
	logic [eeprom_pkg::ADDR_W-1:0]   prog_addr; // word the cycle hits
	logic [eeprom_pkg::WORD_W-1:0]   prog_data; // pattern to write
	logic [eeprom_pkg::WORD_W-1:0]   rd_word;   // word handed to link
	logic [eeprom_pkg::WORD_W-1:0]   mem [eeprom_pkg::WORDS]; // array

	// ************************************************************
	// word update
	// ************************************************************
	// new value of one word at the end of a cycle
	function automatic logic [eeprom_pkg::WORD_W-1:0] next_word(
		input eeprom_pkg::prog_kind_t        kind,
		input logic [eeprom_pkg::WORD_W-1:0] old,
		input logic [eeprom_pkg::WORD_W-1:0] pat
	);
		logic [eeprom_pkg::WORD_W-1:0] res;
		res = old;
		unique case (kind)
			eeprom_pkg::PK_ERASE: res = eeprom_pkg::WORD_ERASED;
			eeprom_pkg::PK_WRITE: res = old & pat;
			eeprom_pkg::PK_AUTO:  res = pat;
			default:              res = old;
		endcase
		return res;
	endfunction

	// ************************************************************
	// link decode
	// ************************************************************
	// a low select clears the frame at once, so a clock that stops
	// mid-instruction cannot leave a stale partial frame behind
	wire       link_clr  = srst | ~chip_select_line;
	wire [7:0] hdr_next  = {hdr_sh[6:0], serial_in_line};
	wire [1:0] op_next   = hdr_next[eeprom_pkg::OP_HI:eeprom_pkg::OP_LO];
	wire [1:0] sub_next  = hdr_next[eeprom_pkg::SUB_HI:eeprom_pkg::SUB_LO];
	wire       hdr_last  = (state == eeprom_pkg::LS_HDR) &&
	                       (cnt == eeprom_pkg::CNT_HDR_LAST);
	wire       is_read   = (op_next == eeprom_pkg::OP_READ);
	// writes and write-all carry a data word
	wire       with_data = (op_next == eeprom_pkg::OP_WRITE) ||
	                       ((op_next == eeprom_pkg::OP_EXT) &&
	                        (sub_next == eeprom_pkg::SUB_WRALL));
	wire       data_last = (state == eeprom_pkg::LS_DATA) &&
	                       (cnt == eeprom_pkg::CNT_DATA_LAST);
	wire       cmd_fire  = (hdr_last && !is_read && !with_data) || data_last;

	// ************************************************************
	// link sequencer, rising serial clock
	// ************************************************************
	// bits are taken on rising edges while select is high
	always_ff @(posedge serial_clock_line or posedge link_clr) begin
		if (link_clr) begin
			state     <= eeprom_pkg::LS_IDLE;
			cnt       <= 5'h00;
			rd_oe     <= 1'b0;
			link_do   <= 1'b0;
			read_req  <= 1'b0;
			data_done <= 1'b0;
			out_sh    <= 16'h0000;
		end else begin
			unique case (state)
				// zeros before the start bit are skipped
				eeprom_pkg::LS_IDLE: begin
					if (serial_in_line) begin
						state <= eeprom_pkg::LS_HDR;
					end
					cnt <= 5'h00;
				end
				// eight header bits, then branch on the op code
				eeprom_pkg::LS_HDR: begin
					cnt <= cnt + 5'h01;
					if (hdr_last) begin
						if (is_read) begin
							state    <= eeprom_pkg::LS_READ;
							read_req <= 1'b1;
							rd_oe    <= 1'b1;
							link_do  <= 1'b0;
						end else if (with_data) begin
							state <= eeprom_pkg::LS_DATA;
						end else begin
							state <= eeprom_pkg::LS_DONE;
						end
					end
				end
				// sixteen data bits, most significant first
				eeprom_pkg::LS_DATA: begin
					cnt <= cnt + 5'h01;
					if (data_last) begin
						state     <= eeprom_pkg::LS_DONE;
						data_done <= 1'b1;
					end
				end
				// the word is ready a full serial period after the header
				eeprom_pkg::LS_READ: begin
					cnt <= cnt + 5'h01;
					if (cnt == eeprom_pkg::CNT_RD_FIRST) begin
						link_do <= rd_word[15];
						out_sh  <= {rd_word[14:0], 1'b0};
					end else if (cnt == eeprom_pkg::CNT_RD_END) begin
						rd_oe <= 1'b0;
						state <= eeprom_pkg::LS_DONE;
					end else begin
						link_do <= out_sh[15];
						out_sh  <= {out_sh[14:0], 1'b0};
					end
				end
				// extra clocks in a finished frame do nothing
				eeprom_pkg::LS_DONE: begin
					cnt <= cnt;
				end
			endcase
		end
	end

	// ************************************************************
	// link shifters and event toggles
	// ************************************************************
	// these survive the select fall so the core can still read them
	always_ff @(posedge serial_clock_line or posedge srst) begin
		if (srst) begin
			hdr_sh  <= 8'h00;
			data_sh <= 16'h0000;
			cmd_tgl <= 1'b0;
		end else begin
			if (state == eeprom_pkg::LS_HDR) begin
				hdr_sh <= hdr_next;
			end
			if (state == eeprom_pkg::LS_DATA) begin
				data_sh <= {data_sh[14:0], serial_in_line};
			end
			if (cmd_fire && chip_select_line) begin
				cmd_tgl <= ~cmd_tgl;
			end
		end
	end

	// select still high at the falling edge after the last data bit
	// marks a plain write; an earlier fall means autoerase
	always_ff @(negedge serial_clock_line or posedge srst) begin
		if (srst) begin
			done_seen <= 1'b0;
			plain_tgl <= 1'b0;
		end else begin
			done_seen <= data_done;
			if (data_done && !done_seen && chip_select_line) begin
				plain_tgl <= ~plain_tgl;
			end
		end
	end

	// ************************************************************
	// core synchronisers
	// ************************************************************
	// a pin level counts once the second and third stage agree
	wire [1:0] pin_next = (pin_q2 & pin_q3) | (pin_state & (pin_q2 ^ pin_q3));
	wire       sel      = pin_state[eeprom_pkg::PIN_SEL];
	wire       sel_fall = sel && !pin_next[eeprom_pkg::PIN_SEL];
	wire       bulk_ok  = pin_state[eeprom_pkg::PIN_BULK];
	wire       read_seen  = lk_s2[0];
	wire       cmd_edge   = lk_s2[1] ^ lk_s3[0];
	wire       plain_edge = lk_s2[2] ^ lk_s3[1];

	// pin and link-event stages
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pin_q1    <= eeprom_pkg::PIN_RESET;
			pin_q2    <= eeprom_pkg::PIN_RESET;
			pin_q3    <= eeprom_pkg::PIN_RESET;
			pin_state <= eeprom_pkg::PIN_RESET;
			lk_s1     <= 3'h0;
			lk_s2     <= 3'h0;
			lk_s3     <= 2'h0;
		end else begin
			pin_q1    <= {bulk_program_allow, chip_select_line};
			pin_q2    <= pin_q1;
			pin_q3    <= pin_q2;
			pin_state <= pin_next;
			lk_s1     <= {plain_tgl, cmd_tgl, read_req};
			lk_s2     <= lk_s1;
			lk_s3     <= lk_s2[2:1];
		end
	end

	// ************************************************************
	// instruction execution decode
	// ************************************************************
	wire [1:0] p_op  = pend_hdr[eeprom_pkg::OP_HI:eeprom_pkg::OP_LO];
	wire [1:0] p_sub = pend_hdr[eeprom_pkg::SUB_HI:eeprom_pkg::SUB_LO];
	wire       p_ext = (p_op == eeprom_pkg::OP_EXT);
	// programming starts on the select fall that ends the instruction
	wire exec      = sel_fall && pend && !busy;
	wire go_en     = exec && p_ext && (p_sub == eeprom_pkg::SUB_EN);
	wire go_dis    = exec && p_ext && (p_sub == eeprom_pkg::SUB_DIS);
	wire go_erase  = exec && prog_en && (p_op == eeprom_pkg::OP_ERASE);
	wire go_write  = exec && prog_en && (p_op == eeprom_pkg::OP_WRITE);
	wire go_erall  = exec && prog_en && p_ext && bulk_ok &&
	                 (p_sub == eeprom_pkg::SUB_ERALL);
	wire go_wrall  = exec && prog_en && p_ext && bulk_ok &&
	                 (p_sub == eeprom_pkg::SUB_WRALL);
	wire start     = go_erase || go_write || go_erall || go_wrall;
	wire commit    = busy && (timer == eeprom_pkg::TIMER_LAST);
	eeprom_pkg::prog_kind_t next_kind;
	assign next_kind = (go_erase || go_erall) ? eeprom_pkg::PK_ERASE :
	                   (go_write && !pend_plain) ? eeprom_pkg::PK_AUTO :
	                   eeprom_pkg::PK_WRITE;

	// ************************************************************
	// pending instruction
	// ************************************************************
	// a finished instruction waits here for the select fall
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pend       <= 1'b0;
			pend_plain <= 1'b0;
			pend_hdr   <= 8'h00;
			pend_data  <= 16'h0000;
		end else if (cmd_edge) begin
			pend       <= 1'b1;
			pend_plain <= plain_edge;
			pend_hdr   <= hdr_sh;
			pend_data  <= data_sh;
		end else begin
			if (plain_edge) begin
				pend_plain <= 1'b1;
			end
			if (sel_fall) begin
				pend <= 1'b0;
			end
		end
	end

	// ************************************************************
	// program enable and self-timed cycle
	// ************************************************************
	// the enable is lost only by the disable instruction or reset
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			prog_en <= 1'b0;
		end else if (go_en) begin
			prog_en <= 1'b1;
		end else if (go_dis) begin
			prog_en <= 1'b0;
		end
	end

	// the timer runs on sys_clk, so a stopped serial clock is harmless
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			busy      <= 1'b0;
			timer     <= 20'h00000;
			prog_kind <= eeprom_pkg::PK_ERASE;
			prog_all  <= 1'b0;
			prog_addr <= 6'h00;
			prog_data <= 16'h0000;
		end else if (start) begin
			busy      <= 1'b1;
			timer     <= PROG_CYCLES;
			prog_kind <= next_kind;
			prog_all  <= go_erall || go_wrall;
			prog_addr <= pend_hdr[eeprom_pkg::ADDR_W-1:0];
			prog_data <= pend_data;
		end else if (busy) begin
			timer <= timer - 20'h00001;
			if (commit) begin
				busy <= 1'b0;
			end
		end
	end

	// status shows after a started cycle while select is high again
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			armed <= 1'b0;
		end else if (start) begin
			armed <= 1'b1;
		end else if (sel_fall && !busy) begin
			armed <= 1'b0;
		end
	end

	// ************************************************************
	// array
	// ************************************************************
	// hand the addressed word to the link; the header is stable here
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rd_word <= 16'h0000;
		end else if (read_seen) begin
			rd_word <= mem[hdr_sh[eeprom_pkg::ADDR_W-1:0]];
		end
	end

	// each word updates only at the end of its cycle
	for (genvar i = 0; i < eeprom_pkg::WORDS; i++) begin : g_word
		wire hit = commit && (prog_all ||
		           (prog_addr == eeprom_pkg::ADDR_W'(i)));
		always_ff @(posedge sys_clk) begin
			if (srst) begin
				mem[i] <= eeprom_pkg::WORD_ERASED;
			end else if (hit) begin
				mem[i] <= next_word(prog_kind, mem[i], prog_data);
			end
		end
	end

	// ************************************************************
	// serial output
	// ************************************************************
	// read data wins; otherwise low while busy, high when ready
	assign serial_out_line = rd_oe ? link_do : ~busy;
	assign serial_out_oe   = rd_oe | (armed & sel);

endmodule // serial_eeprom_command_port
